// ==== rtl/ssc_align_ctrl.sv ====
`include "ssc_align_regs.svh"

module ssc_align_ctrl import ssc_align_pkg::*; #(
    parameter int DWORD_W = 32,
    parameter logic [DWORD_W-1:0] ALIGN_DWORD = 32'h7b4a4abc
) (
    input wire logic clk,
    input wire logic rstn,
    // Configuration
    input wire logic isExpander,
    input wire logic isDiskDrive,
    input wire logic forwarding,
    input wire logic [`ALIGN_RATE_BITS-1:0] alignRateOutside,
    input wire logic [`ALIGN_RATE_BITS-1:0] alignRateSsp,
    input wire logic [`ALIGN_RATE_BITS-1:0] alignRateSmp,
    input wire logic [`ALIGN_RATE_BITS-1:0] alignRateStp,
    input wire logic [1:0] connType,
    // Reset sequencer events
    input wire logic oobStart,
    input wire logic sataSnStart,
    input wire logic sasSnwStart,
    input wire logic capValid,
    input wire logic partnerIsSata,
    input wire logic partnerSscRx,
    input wire logic [`RATE_BITS-1:0] partnerRates,
    input wire logic [`RATE_BITS-1:0] localRates,
    input wire logic finalSnwStart,
    // Link clock from the recovered receive path
    input wire logic linkClk,
    // Source dwords
    input wire logic srcValid,
    output logic srcReady,
    input wire logic [DWORD_W-1:0] srcData,
    // Transmit dwords
    output logic txValid,
    input wire logic txReady,
    output logic [DWORD_W-1:0] txData,
    output logic txIsAlign,
    // Status
    output logic [1:0] txSpread,
    output logic sscActive,
    output logic [`RATE_BITS-1:0] finalRate,
    output logic [1:0] rxTolerance,
    output logic linkEdge
);
    ////////////////////////////////////////////////////////////////////////
    // Link clock sampling
    // Asynchronous link clock: two stages before any edge logic reads it
    // Previous-level stage resets low, the idle level, so no false edge after reset
    logic linkSync1_reg;
    logic linkSync2_reg;
    logic linkPrev_reg;
    logic linkEdge_reg;
    logic linkEdge_next;


    always_comb begin
        linkEdge_next = linkSync2_reg && !linkPrev_reg;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            linkSync1_reg <= 1'b0;
            linkSync2_reg <= 1'b0;
            linkPrev_reg <= 1'b0;
            linkEdge_reg <= 1'b0;
        end else begin
            linkSync1_reg <= linkClk;
            linkSync2_reg <= linkSync1_reg;
            linkPrev_reg <= linkSync2_reg;
            linkEdge_reg <= linkEdge_next;
        end
    end
    assign linkEdge = linkEdge_reg;

    ////////////////////////////////////////////////////////////////////////
    // Spreading selection and reset sequence
    function automatic logic [`RATE_BITS-1:0] highestCommon(input logic [`RATE_BITS-1:0] a,
                                                             input logic [`RATE_BITS-1:0] b);
        logic [`RATE_BITS-1:0] both;
        both = a & b;
        highestCommon = '0;
        for (int i = 0; i < `RATE_BITS; i++) begin
            if (both[i]) begin
                highestCommon = `RATE_BITS'(1) << i;
            end
        end
    endfunction

    function automatic spread_t pickSpread(input logic exp, input logic sata, input logic ssc);
        if (sata) begin
            pickSpread = SPREAD_DOWN;
        end else if (ssc) begin
            pickSpread = exp ? SPREAD_CENTER : SPREAD_DOWN;
        end else begin
            pickSpread = SPREAD_NONE;
        end
    endfunction

    // Capability is captured in the G3 window and held until the final window applies it
    // Spreading only changes on a sequencer event, never inside a window
    phase_t phase_reg, phase_next;
    spread_t spread_reg, spread_next;
    spread_t chosen_reg, chosen_next;
    logic sscRx_reg, sscRx_next;
    logic sata_reg, sata_next;
    logic [`RATE_BITS-1:0] rate_reg, rate_next;
    logic [1:0] rxTol_reg, rxTol_next;

    always_comb begin
        phase_next = phase_reg;
        spread_next = spread_reg;
        chosen_next = chosen_reg;
        sscRx_next = sscRx_reg;
        sata_next = sata_reg;
        rate_next = rate_reg;
        if (capValid) begin
            // G3 capability: rates and receive-spreading support
            sscRx_next = partnerSscRx;
            sata_next = partnerIsSata;
            rate_next = highestCommon(localRates, partnerRates);
            chosen_next = pickSpread(isExpander, partnerIsSata, partnerSscRx);
        end
        if (oobStart) begin
            phase_next = PH_OOB;
            spread_next = SPREAD_NONE;
        end else if (sataSnStart) begin
            phase_next = PH_SATA_SN;
            spread_next = SPREAD_DOWN;
        end else if (sasSnwStart) begin
            phase_next = PH_SAS_SNW;
            spread_next = SPREAD_NONE;
        end else if (finalSnwStart) begin
            phase_next = PH_FINAL;
            spread_next = (sata_reg || sscRx_reg) ? chosen_reg : SPREAD_NONE;
        end else if (phase_reg == PH_FINAL) begin
            phase_next = PH_ACTIVE;
        end
        // Receive tolerance class: 0 SAS set, 1 SATA set
        // Class holds through out-of-band and both negotiations, spread or not
        rxTol_next = (!isDiskDrive && sata_reg) ? 2'h1 : 2'h0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= PH_IDLE;
            spread_reg <= SPREAD_NONE;
            chosen_reg <= SPREAD_NONE;
            sscRx_reg <= 1'b0;
            sata_reg <= 1'b0;
            rate_reg <= '0;
            rxTol_reg <= 2'h0;
        end else begin
            phase_reg <= phase_next;
            spread_reg <= spread_next;
            chosen_reg <= chosen_next;
            sscRx_reg <= sscRx_next;
            sata_reg <= sata_next;
            rate_reg <= rate_next;
            rxTol_reg <= rxTol_next;
        end
    end

    assign txSpread = spread_reg;
    assign finalRate = rate_reg;
    assign rxTolerance = rxTol_reg;

    // Registered from the next value so it moves together with txSpread
    logic sscActive_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sscActive_reg <= 1'b0;
        end else begin
            sscActive_reg <= (spread_next != SPREAD_NONE);
        end
    end
    assign sscActive = sscActive_reg;

    ////////////////////////////////////////////////////////////////////////
    // Source buffer
    logic bufValid, bufReady;
    logic [DWORD_W-1:0] bufData;

    dword_skid_buffer #(.WIDTH(DWORD_W)) srcBuf (
        .clk(clk),
        .rstn(rstn),
        .inValid(srcValid),
        .inReady(srcReady),
        .inData(srcData),
        .outValid(bufValid),
        .outReady(bufReady),
        .outData(bufData)
    );

    ////////////////////////////////////////////////////////////////////////
    // ALIGN insertion, one dword per link edge
    // A slot is lost while the output word still waits; the span only counts used slots
    // Owed ALIGNs are forced at the span end so data goes first
    // Forwarding never inserts on a count, only when the buffer runs empty
    logic [`SPAN_BITS-1:0] spanCnt_reg, spanCnt_next;
    logic [`ALIGN_RATE_BITS-1:0] alignCnt_reg, alignCnt_next, progRate;
    logic txValid_reg, txValid_next;
    logic txAlign_reg, txAlign_next;
    logic [DWORD_W-1:0] txData_reg, txData_next;
    logic slotFree;
    logic needAlign;
    logic sendAlign;
    logic remaining;


    always_comb begin
        unique case (conn_t'(connType))
            CONN_OUTSIDE: progRate = alignRateOutside;
            CONN_SSP: progRate = alignRateSsp;
            CONN_SMP: progRate = alignRateSmp;
            CONN_STP: progRate = alignRateStp;
        endcase
        if (spread_reg == SPREAD_NONE) begin
            progRate = '0;
        end
        slotFree = !txValid_reg || txReady;
        // Remaining slots in span versus ALIGNs still owed
        remaining = ({1'b0, ~spanCnt_reg} + 9'h1) <= {1'b0, progRate - alignCnt_reg};
        needAlign = !forwarding && (alignCnt_reg < progRate) && remaining;
        sendAlign = forwarding ? !bufValid : (needAlign || !bufValid);
        bufReady = linkEdge_reg && slotFree && !sendAlign;
        spanCnt_next = spanCnt_reg;
        alignCnt_next = alignCnt_reg;
        txValid_next = txValid_reg && !txReady;
        txAlign_next = txAlign_reg;
        txData_next = txData_reg;
        if (linkEdge_reg && slotFree) begin
            spanCnt_next = spanCnt_reg + `SPAN_BITS'(1);
            txValid_next = 1'b1;
            txAlign_next = sendAlign;
            txData_next = sendAlign ? ALIGN_DWORD : bufData;
            if (spanCnt_reg == `SPAN_BITS'(`SPAN_DWORDS - 1)) begin
                alignCnt_next = '0;
            end else if (sendAlign && alignCnt_reg != '1) begin
                alignCnt_next = alignCnt_reg + `ALIGN_RATE_BITS'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spanCnt_reg <= '0;
            alignCnt_reg <= '0;
            txValid_reg <= 1'b0;
            txAlign_reg <= 1'b0;
            txData_reg <= '0;
        end else begin
            spanCnt_reg <= spanCnt_next;
            alignCnt_reg <= alignCnt_next;
            txValid_reg <= txValid_next;
            txAlign_reg <= txAlign_next;
            txData_reg <= txData_next;
        end
    end

    assign txValid = txValid_reg;
    assign txData = txData_reg;
    assign txIsAlign = txAlign_reg;
endmodule // ssc_align_ctrl

// ==== rtl/ssc_align_regs.svh ====
`ifndef SSC_ALIGN_REGS_SVH
`define SSC_ALIGN_REGS_SVH
`define SPAN_DWORDS 256
`define SPAN_BITS 8
`define ALIGN_RATE_SSC 4
`define ALIGN_RATE_BITS 8
`define RATE_BITS 3
`define CLK_PERIOD_NS 20
`define LINK_PERIOD_NS 160
`endif

// ==== rtl/ssc_align_pkg.sv ====
package ssc_align_pkg;
    typedef enum logic [1:0] {SPREAD_NONE, SPREAD_DOWN, SPREAD_CENTER} spread_t;
    typedef enum logic [1:0] {CONN_OUTSIDE, CONN_SSP, CONN_SMP, CONN_STP} conn_t;
    typedef enum logic [2:0] {PH_IDLE, PH_OOB, PH_SATA_SN, PH_SAS_SNW, PH_FINAL, PH_ACTIVE} phase_t;
endpackage

// ==== rtl/dword_skid_buffer.sv ====
module dword_skid_buffer #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem0_next, mem1_next;
    logic wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [1:0] count_reg, count_next;
    logic push, pop;
    logic inReady_reg, inReady_next;

    // Ready comes from a flop so the top output is registered
    assign inReady = inReady_reg;
    assign outValid = (count_reg != 2'h0);
    assign outData = mem_reg[rdPtr_reg];

    always_comb begin
        push = inValid && inReady_reg;
        pop = outValid && outReady;
        mem0_next = mem_reg[0];
        mem1_next = mem_reg[1];
        if (push && !wrPtr_reg) begin
            mem0_next = inData;
        end
        if (push && wrPtr_reg) begin
            mem1_next = inData;
        end
        wrPtr_next = wrPtr_reg ^ push;
        rdPtr_next = rdPtr_reg ^ pop;
        count_next = count_reg + {1'b0, push} - {1'b0, pop};
        inReady_next = (count_next != 2'h2);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wrPtr_reg <= 1'b0;
            rdPtr_reg <= 1'b0;
            count_reg <= 2'h0;
            inReady_reg <= 1'b1;
        end else begin
            mem_reg[0] <= mem0_next;
            mem_reg[1] <= mem1_next;
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
            inReady_reg <= inReady_next;
        end
    end
endmodule // dword_skid_buffer

// ==== dv/ssc_align_ctrl_sva.sv ====
module ssc_align_ctrl_sva import ssc_align_pkg::*; #(
    parameter int DWORD_W = 32,
    parameter logic [DWORD_W-1:0] ALIGN_DWORD = 32'h7b4a4abc
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic isExpander,
    input wire logic partnerIsSata,
    input wire logic partnerSscRx,
    input wire logic oobStart,
    input wire logic sataSnStart,
    input wire logic sasSnwStart,
    input wire logic finalSnwStart,
    input wire logic linkClk,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [DWORD_W-1:0] txData,
    input wire logic txIsAlign,
    input wire logic [1:0] txSpread,
    input wire logic sscActive,
    input wire logic linkEdge
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_oob_unspread: assert property (oobStart |=> txSpread == SPREAD_NONE) else $error("oob spread");
    a_sata_sn_down: assert property (sataSnStart && !oobStart |=> txSpread == SPREAD_DOWN) else $error("sn");
    a_snw_unspread: assert property (sasSnwStart && !oobStart && !sataSnStart |=> txSpread == SPREAD_NONE)
        else $error("snw spread");
    a_final_center: assert property (finalSnwStart && isExpander && partnerSscRx && !partnerIsSata
        |=> txSpread == SPREAD_CENTER) else $error("no center");
    a_final_down: assert property (finalSnwStart && (partnerIsSata || !isExpander && partnerSscRx)
        |=> txSpread == SPREAD_DOWN) else $error("no down");
    a_end_not_fast: assert property (!isExpander |-> txSpread != SPREAD_CENTER) else $error("end fast");
    a_spread_holds: assert property (sscActive && !oobStart && !sasSnwStart && !finalSnwStart |=> sscActive)
        else $error("spread dropped");
    a_active_match: assert property (sscActive == (txSpread != SPREAD_NONE)) else $error("active");
    a_tx_holds: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txIsAlign))
        else $error("tx word changed");
    a_align_word: assert property (txValid && txIsAlign |-> txData == ALIGN_DWORD) else $error("align");
    a_slot_pulse: assert property ($rose(linkClk) |-> ##[3:5] linkEdge) else $error("no slot");
endmodule // ssc_align_ctrl_sva

// ==== dv/tx_sink_model.sv ====
module tx_sink_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic stall,
    input wire logic slow,
    input wire logic linkOn,
    input wire logic txValid,
    input wire logic txIsAlign,
    input wire logic [31:0] txData,
    output logic txReady,
    output logic linkClk,
    output int aligns,
    output int errs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] nextWord;
    logic [7:0] cnt;
    // Link clock stands still, held low, while linkOn is low
    initial begin
        linkClk = 1'b0;
        #7;
        forever #80 linkClk = linkOn ? ~linkClk : 1'b0;
    end
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {cnt, nextWord, txReady} <= '0;
            aligns <= 0;
            errs <= 0;
        end else begin
            cnt <= cnt + 8'h1;
            txReady <= !stall && (cnt[0] || !slow);
            if (txValid && txReady && txIsAlign) aligns <= aligns + 1;
            if (txValid && txReady && !txIsAlign) begin
                if (txData !== nextWord) errs <= errs + 1;
                nextWord <= txData + 32'h1;
            end
        end
    end
endmodule // tx_sink_model

// ==== dv/ssc_align_ctrl_tb_top.sv ====
module ssc_align_ctrl_tb_top import ssc_align_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, isExpander, isDiskDrive, forwarding, capValid, partnerIsSata, partnerSscRx;
    logic oobStart, sataSnStart, sasSnwStart, finalSnwStart, linkClk, srcValid, srcReady;
    logic txValid, txReady, txIsAlign, sscActive, linkEdge, stall, slow, linkOn, srcOn;
    logic [7:0] alignRateOutside, alignRateSsp, alignRateSmp, alignRateStp;
    logic [1:0] connType, txSpread, rxTolerance;
    logic [2:0] partnerRates, localRates, finalRate;
    logic [31:0] srcData, txData;
    logic [4:0] ev;
    int failCount, nTests, aligns, errs, b;
    assign {capValid, finalSnwStart, sasSnwStart, sataSnStart, oobStart} = ev;
    ssc_align_ctrl dut_u (.*);
    tx_sink_model sink_u (.clk(clk), .rstn(rstn), .stall(stall), .slow(slow), .linkOn(linkOn), .txValid(txValid),
        .txIsAlign(txIsAlign), .txData(txData), .txReady(txReady), .linkClk(linkClk), .aligns(aligns), .errs(errs));
    always #10 clk = ~clk;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            srcValid <= 1'b0;
            srcData <= 32'h0;
        end else begin
            if (srcValid && srcReady) srcData <= srcData + 32'h1;
            if (!srcValid || srcReady) srcValid <= srcOn;
        end
    end
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic printVerdict();
        if (failCount == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 5'h0;
        @(posedge clk);
    endtask
    task automatic slots(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (linkEdge !== 1'b1 && k < 40);
            if (k >= 40) begin
                failCount++;
                printVerdict();
            end
        end
        @(posedge clk);
    endtask
    task automatic tSpread(input logic x, d, s, c, input logic [2:0] pr, fr, input logic [1:0] fin);
        isExpander <= x;
        isDiskDrive <= d;
        partnerIsSata <= s;
        partnerSscRx <= c;
        partnerRates <= pr;
        pulse(0);
        chk("oobSpread", txSpread, SPREAD_NONE);
        pulse(s ? 1 : 2);
        chk("snSpread", sscActive, s);
        pulse(4);
        pulse(3);
        chk("finalSpread", txSpread, fin);
        chk("finalRate", finalRate, fr);
        chk("rxTolerance", rxTolerance, s);
        repeat (50) @(posedge clk);
        chk("spreadHold", txSpread, fin);
    endtask
    task automatic tAlign();
        int rt [4] = '{4, 6, 8, 12};
        srcOn <= 1'b1;
        linkOn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            connType <= 2'(i);
            slots(8);
            b = aligns;
            slots(512);
            chk("alignMin", 32'(aligns - b >= rt[i]), 1);
            chk("alignMax", 32'(aligns - b <= 3 * rt[i]), 1);
        end
    endtask
    task automatic tStall();
        stall <= 1'b1;
        slots(6);
        chk("srcRefused", srcReady, 0);
        chk("txHeld", txValid, 1);
        stall <= 1'b0;
        slow <= 1'b1;
        slots(64);
        slow <= 1'b0;
        chk("noLoss", errs, 0);
    endtask
    task automatic tForward();
        forwarding <= 1'b1;
        slots(8);
        b = aligns;
        slots(256);
        chk("fwdNoAlign", aligns - b, 0);
        srcOn <= 1'b0;
        slots(8);
        b = aligns;
        slots(64);
        chk("fwdUnderflow", 32'(aligns - b >= 60), 1);
    endtask
    initial begin
        {clk, rstn, isExpander, isDiskDrive, forwarding, partnerIsSata, partnerSscRx} = '0;
        {stall, slow, linkOn, srcOn, ev, connType, partnerRates} = '0;
        localRates = 3'h7;
        {alignRateOutside, alignRateSsp, alignRateSmp, alignRateStp} = {8'h04, 8'h06, 8'h08, 8'h0c};
        repeat (4) @(posedge clk);
        chk("txValidReset", txValid, 0);
        chk("srcReadyReset", srcReady, 1);
        chk("spreadReset", txSpread, 0);
        rstn <= 1'b1;
        @(posedge clk);
        tSpread(0, 1, 0, 1, 3'h3, 3'h2, SPREAD_DOWN);
        tSpread(0, 0, 0, 0, 3'h7, 3'h4, SPREAD_NONE);
        tSpread(1, 0, 0, 1, 3'h5, 3'h4, SPREAD_CENTER);
        tSpread(1, 0, 0, 0, 3'h1, 3'h1, SPREAD_NONE);
        tSpread(1, 0, 1, 0, 3'h3, 3'h2, SPREAD_DOWN);
        tSpread(0, 0, 1, 0, 3'h7, 3'h4, SPREAD_DOWN);
        tAlign();
        tStall();
        tForward();
        printVerdict();
    end
endmodule // ssc_align_ctrl_tb_top
bind ssc_align_ctrl ssc_align_ctrl_sva #(.DWORD_W(DWORD_W), .ALIGN_DWORD(ALIGN_DWORD)) sva_u (.*);
